// *** logic/ltr_regs.sv ***
/*
  Line-side tone and ring status registers behind an AXI4-Lite slave.
  Holds billing/overload flags, ring control, interrupt status and mask.
  Assumes detector inputs and line inputs arrive asynchronously and are
  synchronised here; ring samples arrive on aclk.
  Assumes the host keeps at most one write and one read outstanding and
  carries register bits in byte lane 0 only; other lanes are ignored.
  Unmapped offsets answer with an error response and change nothing.
*/
// Added by the designer: the AXI4-Lite register port.
module ltr_regs
  import ltr_pkg::*;
#(
  parameter int unsigned SW = 16
) (
  input wire logic aclk,
  input wire logic aresetn,
  // Write address, data and response channels
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // Read address and data channels
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Line pins, asynchronous to aclk
  input wire logic tone_present,
  input wire logic rx_overload,
  input wire logic hook_request,
  // Ring samples, already on aclk
  input wire logic ring_valid,
  input wire logic [SW-1:0] ring_sample,
  // Line-side outputs and interrupt
  output logic off_hook,
  output logic ring_squelch,
  output logic serial_receive_valid,
  output logic [SW-1:0] serial_receive_out,
  output logic irq
);
  // Register fields
  logic billing_tone_enable;
  logic billing_tone_detected;
  logic receive_overload;
  logic ring_full_wave_active;
  logic fw_request;
  logic [IRQ_W-1:0] irq_status;
  logic [IRQ_W-1:0] irq_mask;
  logic [IRQ_W-1:0] irq_event;

  // Synchronised line inputs and detected events
  logic [2:0] line_sync;
  logic tone_s;
  logic ovl_s;
  logic hook_s;
  logic ovl_prev;
  logic tone_event;
  logic ovl_event;

  // Write path: address and data held until both are in
  logic aw_held;
  logic w_held;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_fire;
  logic wr_lane0;
  logic [REG_W-1:0] wbyte;

  // Read path
  logic [REG_W-1:0] billing_rd;
  logic [REG_W-1:0] ring_rd;
  logic [31:0] next_rdata;
  logic next_rerr;

  // Pins from the line side cross into aclk here
  // Two flops each; nothing reads the first stage
  ltr_sync #(
    .W(3)
  ) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_in({hook_request, rx_overload, tone_present}),
    .sync_out(line_sync)
  );
  assign tone_s = line_sync[0];
  assign ovl_s = line_sync[1];
  assign hook_s = line_sync[2];

  // Tone only counts while detection is enabled
  assign tone_event = billing_tone_enable && tone_s;
  assign ovl_event = ovl_s && !ovl_prev;

  // Event vector in interrupt status bit order
  assign irq_event[IRQ_BTD] = tone_event;
  assign irq_event[IRQ_ROV] = ovl_event;

  // Previous overload level; idle low so reset gives no false edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ovl_prev <= 1'b0;
    end else begin
      ovl_prev <= ovl_s;
    end
  end

  // Write channel capture: address and data accepted in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_held <= 1'b0;
      end
    end
  end

  // Ready only when the slot is empty and no response is pending
  // Registered ready costs a cycle per write but keeps the path short
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held && !s_axi_bvalid &&
                       !(s_axi_awvalid && s_axi_awready);
      s_axi_wready <= !w_held && !s_axi_bvalid &&
                      !(s_axi_wvalid && s_axi_wready);
    end
  end

  assign wr_fire = aw_held && w_held && !s_axi_bvalid;
  assign wr_lane0 = wr_fire && w_strb[0];
  assign wbyte = w_data[REG_W-1:0];

  // Write response; unmapped addresses answer with an error
  // Response waits for bready; no new write is taken meanwhile
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      unique case (aw_addr)
        ADDR_BILLING, ADDR_RING, ADDR_IRQ_STATUS, ADDR_IRQ_MASK,
        ADDR_LINE_CTRL: s_axi_bresp <= RESP_OKAY;
        default: s_axi_bresp <= RESP_SLVERR;
      endcase
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Enable bit is the only plain writable field of the billing register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      billing_tone_enable <= RST_BILLING[BIT_BTE];
    end else if (wr_lane0 && aw_addr == ADDR_BILLING) begin
      billing_tone_enable <= wbyte[BIT_BTE];
    end
  end

  // Sticky flags: a zero write clears, a one write keeps; set beats clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      billing_tone_detected <= RST_BILLING[BIT_BTD];
      receive_overload <= RST_BILLING[BIT_ROV];
    end else begin
      if (tone_event) begin
        billing_tone_detected <= 1'b1;
      end else if (wr_lane0 && aw_addr == ADDR_BILLING &&
                   !wbyte[BIT_BTD]) begin
        billing_tone_detected <= 1'b0;
      end
      if (ovl_event) begin
        receive_overload <= 1'b1;
      end else if (wr_lane0 && aw_addr == ADDR_BILLING &&
                   !wbyte[BIT_ROV]) begin
        receive_overload <= 1'b0;
      end
    end
  end

  // Squelch is written by the host; rectifier status is read-only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ring_squelch <= RST_RING[BIT_SQUELCH];
    end else if (wr_lane0 && aw_addr == ADDR_RING) begin
      ring_squelch <= wbyte[BIT_SQUELCH];
    end
  end

  // Full-wave mode is requested by software and reported back read-only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fw_request <= 1'b0;
      ring_full_wave_active <= RST_RING[BIT_FULL_WAVE];
    end else begin
      if (wr_lane0 && aw_addr == ADDR_LINE_CTRL) begin
        fw_request <= wbyte[BIT_FW_REQ];
      end
      ring_full_wave_active <= fw_request;
    end
  end

  // Interrupt status per bit: write one to clear, new event wins
  generate
    for (genvar i = 0; i < IRQ_W; i++) begin : g_irq_status
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          irq_status[i] <= 1'b0;
        end else if (irq_event[i]) begin
          irq_status[i] <= 1'b1;
        end else if (wr_lane0 && aw_addr == ADDR_IRQ_STATUS &&
                     wbyte[i]) begin
          irq_status[i] <= 1'b0;
        end
      end
    end
  endgenerate

  // Mask has the status layout; a masked event still latches
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_mask <= '0;
    end else if (wr_lane0 && aw_addr == ADDR_IRQ_MASK) begin
      irq_mask <= wbyte[IRQ_W-1:0];
    end
  end

  // Registered so the interrupt pin comes straight from a flop
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status & irq_mask);
    end
  end

  // Hold off-hook through a tone while detection is enabled
  // Tone path is gated by the enable, so a disabled detector never hooks
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      off_hook <= 1'b0;
    end else begin
      off_hook <= hook_s || (billing_tone_enable && tone_s);
    end
  end

  // Ring samples reflect the rectifier mode on the serial output
  // One cycle through the shaper, so strobe and data stay aligned
  ltr_rectify #(
    .SW(SW)
  ) u_rect (
    .aclk(aclk),
    .aresetn(aresetn),
    .full_wave(ring_full_wave_active),
    .in_valid(ring_valid),
    .in_sample(ring_sample),
    .out_valid(serial_receive_valid),
    .out_sample(serial_receive_out)
  );

  // Readback images; unused bits forced low
  always_comb begin
    billing_rd = '0;
    billing_rd[BIT_BTE] = billing_tone_enable;
    billing_rd[BIT_ROV] = receive_overload;
    billing_rd[BIT_BTD] = billing_tone_detected;
    ring_rd = '0;
    ring_rd[BIT_FULL_WAVE] = ring_full_wave_active;
    ring_rd[BIT_SQUELCH] = ring_squelch;
  end

  // Read decode
  // Combinational on araddr; used only at the address handshake
  always_comb begin
    next_rdata = '0;
    next_rerr = 1'b0;
    unique case (s_axi_araddr)
      ADDR_BILLING: next_rdata[REG_W-1:0] = billing_rd;
      ADDR_RING: next_rdata[REG_W-1:0] = ring_rd;
      ADDR_IRQ_STATUS: next_rdata[IRQ_W-1:0] = irq_status;
      ADDR_IRQ_MASK: next_rdata[IRQ_W-1:0] = irq_mask;
      ADDR_LINE_CTRL: next_rdata[BIT_FW_REQ] = fw_request;
      default: next_rerr = 1'b1;
    endcase
  end

  // One read in flight; address taken only when no data is pending
  // rvalid drops on the rready edge; arready returns one cycle later
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= next_rdata;
        s_axi_rresp <= next_rerr ? RESP_SLVERR : RESP_OKAY;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule : ltr_regs

// *** logic/ltr_pkg.sv ***
/*
  Constants for the line-side tone and ring status register block:
  register indices, byte addresses, field positions, reset values and
  AXI4-Lite response codes.
  Assumes a 32-bit AXI4-Lite bus with one register per aligned word.
*/
package ltr_pkg;
  localparam int unsigned REG_W = 8;
  localparam int unsigned ADDR_W = 8;
  // Printed indices; byte address is four times the index
  localparam logic [7:0] IDX_BILLING = 8'h11;
  localparam logic [7:0] IDX_RING = 8'h12;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h20;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h21;
  localparam logic [7:0] IDX_LINE_CTRL = 8'h22;
  localparam logic [ADDR_W-1:0] ADDR_BILLING = 8'h44;
  localparam logic [ADDR_W-1:0] ADDR_RING = 8'h48;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = 8'h80;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 8'h84;
  localparam logic [ADDR_W-1:0] ADDR_LINE_CTRL = 8'h88;
  // Billing/overload register fields
  localparam int unsigned BIT_BTD = 0;
  localparam int unsigned BIT_ROV = 1;
  localparam int unsigned BIT_BTE = 2;
  // Ring-control register fields
  localparam int unsigned BIT_SQUELCH = 0;
  localparam int unsigned BIT_FULL_WAVE = 1;
  // Interrupt status fields
  localparam int unsigned IRQ_BTD = 0;
  localparam int unsigned IRQ_ROV = 1;
  localparam int unsigned IRQ_W = 2;
  // Line control field: full-wave rectification request
  localparam int unsigned BIT_FW_REQ = 0;
  localparam logic [REG_W-1:0] RST_BILLING = 8'h00;
  localparam logic [REG_W-1:0] RST_RING = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : ltr_pkg

// *** logic/ltr_sync.sv ***
/*
  Two-flip-flop synchroniser for a bundle of level inputs.
  Assumes inputs come from outside the aclk domain.
*/
module ltr_sync #(
  parameter int unsigned W = 1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] stage1;

  // First stage feeds only the second
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stage1 <= '0;
      sync_out <= '0;
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end
endmodule : ltr_sync

// *** logic/ltr_rectify.sv ***
/*
  Ring sample shaper: passes ring-detect samples straight, or folds them
  to magnitude when full-wave rectification is active.
  Assumes two's complement samples on the aclk domain.
*/
module ltr_rectify #(
  parameter int unsigned SW = 16
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic full_wave,
  input wire logic in_valid,
  input wire logic [SW-1:0] in_sample,
  output logic out_valid,
  output logic [SW-1:0] out_sample
);
  logic [SW-1:0] magnitude;

  // Most negative value saturates rather than wrapping
  always_comb begin
    if (!in_sample[SW-1]) begin
      magnitude = in_sample;
    end else if (in_sample == {1'b1, {(SW-1){1'b0}}}) begin
      magnitude = {1'b0, {(SW-1){1'b1}}};
    end else begin
      magnitude = SW'(~in_sample + 1'b1);
    end
  end

  // Registered output stage
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_valid <= 1'b0;
      out_sample <= '0;
    end else begin
      out_valid <= in_valid;
      if (in_valid) begin
        out_sample <= full_wave ? magnitude : in_sample;
      end
    end
  end
endmodule : ltr_rectify

// *** bench/ltr_monitor.sv ***
/*
  Port checker for the tone and ring register block.
  Assumes a bind to ltr_regs and a single aclk domain.
*/
module ltr_monitor
  import ltr_pkg::*;
#(
  parameter int unsigned SW = 16
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_bvalid,
  input wire logic tone_present,
  input wire logic hook_request,
  input wire logic ring_valid,
  input wire logic [SW-1:0] ring_sample,
  input wire logic off_hook,
  input wire logic ring_squelch,
  input wire logic serial_receive_valid,
  input wire logic [SW-1:0] serial_receive_out,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [ADDR_W-1:0] ar_q;
  // Address of the read in flight, to judge the returned bits
  always_ff @(posedge aclk) begin
    if (s_axi_arvalid && s_axi_arready) ar_q <= s_axi_araddr;
  end
  chk_upper_zero:
  assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0
    && !(ar_q == ADDR_BILLING && s_axi_rdata[7:3] != 5'h0)
    && !(ar_q == ADDR_RING && s_axi_rdata[7:2] != 6'h0))
    else $error("reserved read bits not zero");
  chk_read_okay:
  assert property (s_axi_arvalid && s_axi_arready
    && (s_axi_araddr == ADDR_BILLING || s_axi_araddr == ADDR_RING)
    |=> s_axi_rvalid && s_axi_rresp == RESP_OKAY)
    else $error("mapped read not answered okay");
  chk_reset_quiet:
  assert property ($rose(aresetn) |-> !off_hook && !ring_squelch && !irq)
    else $error("outputs not clear after reset");
  chk_hook_follow:
  assert property ($past(hook_request, 3) |-> off_hook)
    else $error("off hook request not followed");
  chk_hook_cause:
  assert property (!$past(hook_request, 3) && !$past(tone_present, 3)
    |-> !off_hook)
    else $error("off hook without cause");
  chk_ring_pass:
  assert property (ring_valid && !ring_sample[SW-1] |=> serial_receive_valid
    && serial_receive_out == $past(ring_sample))
    else $error("positive ring sample altered");
  chk_ring_gap:
  assert property (!ring_valid |=> !serial_receive_valid)
    else $error("sample strobe without input");
  chk_squelch_write:
  assert property ($changed(ring_squelch)
    |-> $past(s_axi_bvalid) or ##[0:2] s_axi_bvalid)
    else $error("squelch moved without a write");
endmodule : ltr_monitor

bind ltr_regs ltr_monitor #(.SW(SW)) i_ltr_monitor (.*);

// *** bench/ltr_host.sv ***
/*
  Host controller model: AXI4-Lite master with write and read tasks.
  Assumes the bench calls its tasks just after a rising edge of aclk.
*/
module ltr_host
  import ltr_pkg::*;
(
  input wire logic aclk,
  output logic [ADDR_W-1:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  output logic [ADDR_W-1:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready,
  output logic hung
);
  timeunit 1ns;
  timeprecision 1ns;
  // Responses always accepted, so the answer is taken at once
  initial begin
    s_axi_awaddr = '0;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = '0;
    s_axi_wstrb = 4'h1;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b1;
    s_axi_araddr = '0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b1;
    hung = 1'b0;
  end
  // Each channel dropped at its own handshake; bound of 50 edges
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 50);
    r = s_axi_bresp;
    if (n >= 50) hung = 1'b1;
  endtask : wr
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 50);
    d = s_axi_rdata;
    r = s_axi_rresp;
    if (n >= 50) hung = 1'b1;
  endtask : rd
endmodule : ltr_host

// *** bench/test_line_side_tone_ring_status_regs.sv ***
/*
  Self-checking bench for the tone and ring register block.
  Assumes the host model for bus cycles and drives line inputs itself.
*/
module test_line_side_tone_ring_status_regs
  import ltr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk, aresetn, tone_present, rx_overload, hook_request;
  logic ring_valid, off_hook, ring_squelch, serial_receive_valid, irq;
  logic [15:0] ring_sample, serial_receive_out;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_v;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, hung;
  int errors, n_checks;
  ltr_regs i_ltr_regs (.*);
  ltr_host i_ltr_host (.*);
  // Free running 100 MHz clock
  always #5 aclk = ~aclk;
  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : cmp_word
  task automatic cmp_bit(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : cmp_bit
  task automatic close_out();
    $display("errors %0d checks %0d", errors, n_checks);
    if (errors == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : close_out
  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask : tick
  // Writes must answer okay; reads compare the whole word
  task automatic wrc(input logic [7:0] a, input logic [31:0] d);
    i_ltr_host.wr(a, d, resp);
    cmp_word({30'h0, resp}, {30'h0, RESP_OKAY});
  endtask : wrc
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    i_ltr_host.rd(a, rd_v, resp);
    cmp_word(rd_v, e);
  endtask : rdc
  // One ring sample, judged one cycle after the strobe
  task automatic send(input logic [15:0] s, input logic [15:0] e);
    ring_sample <= s;
    ring_valid <= 1'b1;
    @(posedge aclk);
    ring_valid <= 1'b0;
    #1;
    cmp_bit(serial_receive_valid, 1'b1);
    cmp_word({16'h0, serial_receive_out}, {16'h0, e});
    @(posedge aclk);
  endtask : send
  task automatic t_reset();
    rdc(ADDR_BILLING, 32'h0);
    rdc(ADDR_RING, 32'h0);
    i_ltr_host.rd(8'h10, rd_v, resp);
    cmp_word({30'h0, resp}, {30'h0, RESP_SLVERR});
    // Unmapped write is refused and leaves the map alone
    i_ltr_host.wr(8'h10, 32'hff, resp);
    cmp_word({30'h0, resp}, {30'h0, RESP_SLVERR});
    rdc(ADDR_BILLING, 32'h0);
  endtask : t_reset
  task automatic t_billing();
    wrc(ADDR_BILLING, 32'hff);
    rdc(ADDR_BILLING, 32'h04);
    tone_present <= 1'b1;
    tick(6);
    rdc(ADDR_BILLING, 32'h05);
    cmp_bit(off_hook, 1'b1);
    tone_present <= 1'b0;
    tick(6);
    cmp_bit(off_hook, 1'b0);
    wrc(ADDR_BILLING, 32'h04);
    rdc(ADDR_BILLING, 32'h04);
    wrc(ADDR_BILLING, 32'h0);
    tone_present <= 1'b1;
    tick(6);
    rdc(ADDR_BILLING, 32'h0);
    cmp_bit(off_hook, 1'b0);
    tone_present <= 1'b0;
    hook_request <= 1'b1;
    tick(5);
    cmp_bit(off_hook, 1'b1);
    hook_request <= 1'b0;
  endtask : t_billing
  // Overload event, masked interrupt, then unmasked, then cleared
  task automatic t_overload();
    wrc(ADDR_IRQ_MASK, 32'h0);
    wrc(ADDR_IRQ_STATUS, 32'h3);
    rx_overload <= 1'b1;
    tick(6);
    rx_overload <= 1'b0;
    rdc(ADDR_BILLING, 32'h02);
    rdc(ADDR_IRQ_STATUS, 32'h02);
    cmp_bit(irq, 1'b0);
    wrc(ADDR_IRQ_MASK, 32'h3);
    tick(2);
    cmp_bit(irq, 1'b1);
    wrc(ADDR_BILLING, 32'h02);
    rdc(ADDR_BILLING, 32'h02);
    wrc(ADDR_IRQ_STATUS, 32'h3);
    tick(2);
    cmp_bit(irq, 1'b0);
    wrc(ADDR_BILLING, 32'h0);
    rdc(ADDR_BILLING, 32'h0);
  endtask : t_overload
  task automatic t_ring();
    wrc(ADDR_RING, 32'hff);
    rdc(ADDR_RING, 32'h01);
    cmp_bit(ring_squelch, 1'b1);
    wrc(ADDR_RING, 32'h0);
    cmp_bit(ring_squelch, 1'b0);
    send(16'hfff0, 16'hfff0);
    wrc(ADDR_LINE_CTRL, 32'h1);
    tick(2);
    rdc(ADDR_RING, 32'h02);
    send(16'hfff0, 16'h0010);
    send(16'h8000, 16'h7fff);
    wrc(ADDR_LINE_CTRL, 32'h0);
  endtask : t_ring
  // Reset in mid-run with fields set: billing, ring and line control return to zero
  task automatic t_rst_mid();
    wrc(ADDR_BILLING, 32'h04);
    wrc(ADDR_RING, 32'h01);
    wrc(ADDR_LINE_CTRL, 32'h1);
    tick(2);
    rdc(ADDR_RING, 32'h03);
    aresetn <= 1'b0;
    tick(10);
    aresetn <= 1'b1;
    tick(2);
    rdc(ADDR_BILLING, 32'h0);
    rdc(ADDR_RING, 32'h0);
    cmp_bit(ring_squelch, 1'b0);
    rdc(ADDR_LINE_CTRL, 32'h0);
  endtask : t_rst_mid
  // A stuck handshake in the host model ends the run
  always @(posedge aclk) begin
    if (hung === 1'b1) begin
      errors++;
      close_out();
    end
  end
  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    tone_present = 1'b0;
    rx_overload = 1'b0;
    hook_request = 1'b0;
    ring_valid = 1'b0;
    ring_sample = 16'h0;
    errors = 0;
    n_checks = 0;
    tick(10);
    aresetn <= 1'b1;
    tick(2);
    t_reset();
    t_billing();
    t_overload();
    t_ring();
    t_rst_mid();
    close_out();
  end
endmodule : test_line_side_tone_ring_status_regs
